// *** scfg_pkg.sv ***
// Shared constants for the synthesizer configuration register bank
package scfg_pkg;
    localparam int          WORD_W        = 24;
    localparam int          CTRL_W        = 4;
    // Control codes in the low four bits of each serial word
    localparam logic [3:0]  CODE_R0       = 4'h0;
    localparam logic [3:0]  CODE_R3       = 4'h7;
    localparam logic [3:0]  CODE_LOOP     = 4'h9;
    localparam logic [3:0]  CODE_EXTFRAC  = 4'hb;
    localparam logic [3:0]  CODE_FAST     = 4'hd;
    localparam logic [3:0]  CODE_TEST     = 4'hf;
    // Access word position inside the word
    localparam int          ACCESS_LSB    = 20;
    // Fixed default contents of the optional words
    localparam logic [23:0] LOOP_DEFAULT    = 24'h02c709;
    localparam logic [23:0] EXTFRAC_DEFAULT = 24'h00000b;
    localparam logic [23:0] FAST_DEFAULT    = 24'h00000d;
    localparam logic [23:0] TEST_DEFAULT    = 24'h00090f; // Bits 11 and 8 are fixed ones
    // Field positions of the loop control word
    localparam int          AUTO_PU_BIT   = 23;
    localparam int          DITHER_LSB    = 16;
    localparam int          MOD_LSB       = 14;
    localparam int          DOUBLER_BIT   = 12;
    localparam int          REFBUF_BIT    = 11;
    localparam int          AUX_POL_BIT   = 10;
    localparam int          MAIN_POL_BIT  = 9;
    localparam int          AUX_PRE_BIT   = 8;
    localparam int          MUX_LSB       = 4;
    // Extended fraction fields
    localparam int          EXT_NUM_LSB   = 4;
    localparam int          EXT_DEN_LSB   = 14;
    // Modulator order codes
    localparam logic [1:0]  MOD_FOURTH    = 2'h0;
    localparam logic [1:0]  MOD_OFF       = 2'h1;
    localparam logic [1:0]  MOD_SECOND    = 2'h2;
    localparam logic [1:0]  MOD_THIRD     = 2'h3;
endpackage

// *** scfg_if.sv ***
// Carrier for the decoded loop control word between top and pin mux
interface scfg_if;
    logic [3:0] testPinSelect;
    logic       doubleRef;
    modport src (output testPinSelect, output doubleRef);
    modport dst (input testPinSelect, input doubleRef);
endinterface

// *** scfg_test_mux.sv ***
// Test and lock pin multiplexer with divided-by-two monitor outputs
module scfg_test_mux (
    input  wire logic clk,
    input  wire logic arst_n,
    scfg_if.dst       cfg,
    input  wire logic mainLockDig,
    input  wire logic auxLockDig,
    input  wire logic mainLockAna,
    input  wire logic auxLockAna,
    input  wire logic auxRefTick,
    input  wire logic auxFbTick,
    input  wire logic mainRefTick,
    input  wire logic mainFbTick,
    output logic      pinOut,
    output logic      pinOe
);
    logic [3:0] halfDiv_reg;
    logic [3:0] tick;
    logic       outNext;
    logic       oeNext;

    assign tick = {mainFbTick, mainRefTick, auxFbTick, auxRefTick};

    // Each divider pulse toggles its own halving flop
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_half
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    halfDiv_reg[i] <= 1'b0;
                end else if (tick[i]) begin
                    halfDiv_reg[i] <= ~halfDiv_reg[i];
                end
            end
        end
    endgenerate

    // Pin function select; open-drain codes only enable the driver when pulling low
    always_comb begin
        outNext = 1'b0;
        oeNext  = 1'b1;
        case (cfg.testPinSelect)
            4'h0: oeNext = 1'b0;
            4'h1: outNext = 1'b1;
            4'h2: outNext = 1'b0;
            4'h3: outNext = mainLockDig & auxLockDig;
            4'h4: outNext = mainLockDig;
            4'h5: outNext = auxLockDig;
            4'h6: oeNext = ~(mainLockAna & auxLockAna);
            4'h7: oeNext = ~mainLockAna;
            4'h8: oeNext = ~auxLockAna;
            4'h9: outNext = mainLockAna & auxLockAna;
            4'ha: outNext = mainLockAna;
            4'hb: outNext = auxLockAna;
            4'hc: outNext = halfDiv_reg[0];
            4'hd: outNext = halfDiv_reg[1];
            4'he: outNext = halfDiv_reg[2];
            4'hf: outNext = halfDiv_reg[3];
            default: oeNext = 1'b0;
        endcase
    end

    // Registered pin drive keeps glitches off the package pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinOut <= 1'b0;
            pinOe  <= 1'b0;
        end else begin
            pinOut <= outNext;
            pinOe  <= oeNext;
        end
    end
endmodule

// *** scfg_regs.sv ***
// Serial configuration bank: access word, optional words and their decode
module scfg_regs
    import scfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        serClk,
    input  wire logic        serData,
    input  wire logic        serLatch,
    input  wire logic        chipEnable,
    input  wire logic        mainLockDig,
    input  wire logic        auxLockDig,
    input  wire logic        mainLockAna,
    input  wire logic        auxLockAna,
    input  wire logic        auxRefTick,
    input  wire logic        auxFbTick,
    input  wire logic        mainRefTick,
    input  wire logic        mainFbTick,
    input  wire logic        refIn,
    output logic             testLockPinOut,
    output logic             testLockPinOe,
    output logic             mainPowerDown,
    output logic             auxPowerDown,
    output logic             auxPrescaler16,
    output logic             mainPumpPositive,
    output logic             auxPumpPositive,
    output logic [1:0]       modulatorOrder,
    output logic [1:0]       ditherLevel,
    output logic             refBufferOutEn,
    output logic             mainRefClk,
    output logic             auxRefClk,
    output logic             fraction22,
    output logic [9:0]       extNumeratorHi,
    output logic [9:0]       extDenominatorHi,
    output logic [WORD_W-1:0] fastlockWord,
    output logic [WORD_W-1:0] testResetWord
);
    // Pin synchronisers: first stage only feeds the second
    logic [2:0] clkSync1_reg, clkSync2_reg;
    logic [2:0] pins;
    logic       serClkPrev_reg;
    logic       latchPrev_reg;
    logic       shiftEdge;
    logic       latchEdge;
    logic [WORD_W-1:0] shift_reg;
    logic [3:0] access_reg;
    logic [WORD_W-1:0] loopWr_reg, extWr_reg, fastWr_reg, testWr_reg;
    logic [WORD_W-1:0] loopWord, extWord;
    logic       ceSync1_reg, ceSync2_reg;
    logic       refSync1_reg, refSync2_reg, refPrev_reg;
    logic       mainPd_reg, auxPd_reg;
    logic [3:0] ctrl;
    scfg_if     cfgBus ();

    assign pins = {serLatch, serData, serClk};

    // Two-flop synchronisers for the serial pins and chip enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clkSync1_reg <= 3'h0;
            clkSync2_reg <= 3'h0;
            ceSync1_reg  <= 1'b0;
            ceSync2_reg  <= 1'b0;
        end else begin
            clkSync1_reg <= pins;
            clkSync2_reg <= clkSync1_reg;
            ceSync1_reg  <= chipEnable;
            ceSync2_reg  <= ceSync1_reg;
        end
    end

    // Edge history for the synchronised serial clock and latch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serClkPrev_reg <= 1'b0;
            latchPrev_reg  <= 1'b0;
        end else begin
            serClkPrev_reg <= clkSync2_reg[0];
            latchPrev_reg  <= clkSync2_reg[2];
        end
    end

    assign shiftEdge = clkSync2_reg[0] & ~serClkPrev_reg;
    assign latchEdge = clkSync2_reg[2] & ~latchPrev_reg;
    assign ctrl      = shift_reg[CTRL_W-1:0];

    // MSB-first shifter; last bit shifted in is C0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= '0;
        end else if (shiftEdge) begin
            shift_reg <= {shift_reg[WORD_W-2:0], clkSync2_reg[1]};
        end
    end

    // Access word held reset leaves all optional words in default
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            access_reg <= 4'h0;
        end else if (latchEdge && ctrl == CODE_R3) begin
            access_reg <= shift_reg[ACCESS_LSB+3:ACCESS_LSB];
        end
    end

    // Optional word storage, steered by control code
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loopWr_reg <= LOOP_DEFAULT;
            extWr_reg  <= EXTFRAC_DEFAULT;
            fastWr_reg <= FAST_DEFAULT;
            testWr_reg <= TEST_DEFAULT;
        end else if (latchEdge) begin
            case (ctrl)
                CODE_LOOP:    loopWr_reg <= shift_reg;
                CODE_EXTFRAC: extWr_reg  <= shift_reg;
                CODE_FAST:    fastWr_reg <= shift_reg;
                CODE_TEST:    testWr_reg <= shift_reg;
                default:      ;
            endcase
        end
    end

    // Written contents apply only while the access bit is set
    assign loopWord = access_reg[0] ? loopWr_reg : LOOP_DEFAULT;
    assign extWord  = access_reg[1] ? extWr_reg  : EXTFRAC_DEFAULT;

    assign cfgBus.testPinSelect = loopWord[MUX_LSB+3:MUX_LSB];
    assign cfgBus.doubleRef     = loopWord[DOUBLER_BIT];

    // Power-down bits; auto power-up on an R0 write unless chip enable is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mainPd_reg <= 1'b1;
            auxPd_reg  <= 1'b1;
        end else if (latchEdge && ctrl == CODE_R0 && loopWord[AUTO_PU_BIT]
                     && ceSync2_reg) begin
            mainPd_reg <= 1'b0;
            auxPd_reg  <= 1'b0;
        end
    end

    // Reference synchroniser; edge history lets the doubler mark both edges,
    // since a true 2x clock cannot be built at this sampling rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            refSync1_reg <= 1'b0;
            refSync2_reg <= 1'b0;
            refPrev_reg  <= 1'b0;
        end else begin
            refSync1_reg <= refIn;
            refSync2_reg <= refSync1_reg;
            refPrev_reg  <= refSync2_reg;
        end
    end

    // Decoded controls, all registered; doubler pulses on both ref edges
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mainPowerDown    <= 1'b1;
            auxPowerDown     <= 1'b1;
            auxPrescaler16   <= 1'b1;
            mainPumpPositive <= 1'b1;
            auxPumpPositive  <= 1'b1;
            modulatorOrder   <= MOD_THIRD;
            ditherLevel      <= 2'h2;
            refBufferOutEn   <= 1'b0;
            mainRefClk       <= 1'b0;
            auxRefClk        <= 1'b0;
            fraction22       <= 1'b0;
            extNumeratorHi   <= 10'h000;
            extDenominatorHi <= 10'h000;
            fastlockWord     <= FAST_DEFAULT;
            testResetWord    <= TEST_DEFAULT;
        end else begin
            mainPowerDown    <= mainPd_reg | ~ceSync2_reg;
            auxPowerDown     <= auxPd_reg | ~ceSync2_reg;
            auxPrescaler16   <= loopWord[AUX_PRE_BIT];
            mainPumpPositive <= loopWord[MAIN_POL_BIT];
            auxPumpPositive  <= loopWord[AUX_POL_BIT];
            modulatorOrder   <= loopWord[MOD_LSB+1:MOD_LSB];
            ditherLevel      <= loopWord[DITHER_LSB+1:DITHER_LSB];
            refBufferOutEn   <= loopWord[REFBUF_BIT];
            auxRefClk        <= refSync2_reg;
            mainRefClk       <= cfgBus.doubleRef ? (refSync2_reg ^ refPrev_reg)
                                                 : refSync2_reg;
            fraction22       <= access_reg[1];
            extNumeratorHi   <= access_reg[1] ? extWord[EXT_NUM_LSB+9:EXT_NUM_LSB]
                                              : 10'h000;
            extDenominatorHi <= access_reg[1] ? extWord[EXT_DEN_LSB+9:EXT_DEN_LSB]
                                              : 10'h000;
            fastlockWord     <= access_reg[2] ? fastWr_reg : FAST_DEFAULT;
            testResetWord    <= access_reg[3] ? testWr_reg : TEST_DEFAULT;
        end
    end

    // Pin mux registers its own outputs
    scfg_test_mux u_mux (
        .clk         (clk),
        .arst_n      (arst_n),
        .cfg         (cfgBus.dst),
        .mainLockDig (mainLockDig),
        .auxLockDig  (auxLockDig),
        .mainLockAna (mainLockAna),
        .auxLockAna  (auxLockAna),
        .auxRefTick  (auxRefTick),
        .auxFbTick   (auxFbTick),
        .mainRefTick (mainRefTick),
        .mainFbTick  (mainFbTick),
        .pinOut      (testLockPinOut),
        .pinOe       (testLockPinOe)
    );
endmodule

// *** scfg_host.sv ***
// Host controller model that shifts words into the serial programming pins
module scfg_host (
    input  wire logic clk,
    output logic      serClk,
    output logic      serData,
    output logic      serLatch
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins idle low until the first word
    initial begin
        serClk = 1'b0;
        serData = 1'b0;
        serLatch = 1'b0;
    end

    // Four cycles per phase, one spare over the pin filter's minimum of three
    task automatic hold();
        repeat (4) @(negedge clk);
    endtask

    // Whole 24-bit word, MSB first, then the latch pulse
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serData = w[i];
            hold();
            serClk = 1'b1;
            hold();
            serClk = 1'b0;
        end
        hold();
        serLatch = 1'b1;
        hold();
        serLatch = 1'b0;
        serData = ~w[0];  // Stale bit never lingers on the released line
    endtask
endmodule

// *** scfg_regs_props.sv ***
// Port-level checker for the serial configuration bank
module scfg_regs_props
    import scfg_pkg::*;
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              serLatch,
    input wire logic              chipEnable,
    input wire logic              mainPowerDown,
    input wire logic              auxPowerDown,
    input wire logic              auxPrescaler16,
    input wire logic              mainPumpPositive,
    input wire logic              auxPumpPositive,
    input wire logic [1:0]        modulatorOrder,
    input wire logic [1:0]        ditherLevel,
    input wire logic              fraction22,
    input wire logic [9:0]        extNumeratorHi,
    input wire logic [9:0]        extDenominatorHi,
    input wire logic [WORD_W-1:0] fastlockWord,
    input wire logic [WORD_W-1:0] testResetWord
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Eight quiet latch cycles: any earlier store has fully landed
    sequence latchQuiet;
        !serLatch [*8];
    endsequence

    // Long enough for chip enable to pass its synchroniser
    sequence ceLowHeld;
        !chipEnable [*4];
    endsequence

    reset_defaults_a: assert property (
        $rose(arst_n) |-> auxPrescaler16 && mainPumpPositive && auxPumpPositive
            && modulatorOrder == MOD_THIRD && ditherLevel == 2'h2)
        else $error("loop outputs not at default after reset");
    quiet_stable_a: assert property (
        latchQuiet |=> $stable({modulatorOrder, ditherLevel, auxPrescaler16,
            fraction22, fastlockWord, testResetWord}))
        else $error("configuration changed without a latch");
    ext_zero_a: assert property (
        !fraction22 |-> extNumeratorHi == 10'h000 && extDenominatorHi == 10'h000)
        else $error("extended fraction set in short mode");
    fast_code_a: assert property (
        fastlockWord[3:0] == CODE_FAST)
        else $error("fastlock word has wrong control code");
    test_code_a: assert property (
        testResetWord[3:0] == CODE_TEST)
        else $error("test word has wrong control code");
    ce_holds_pd_a: assert property (
        ceLowHeld |-> mainPowerDown && auxPowerDown)
        else $error("loop powered while chip enable low");
    pd_together_a: assert property (
        $fell(mainPowerDown) |-> $fell(auxPowerDown))
        else $error("loops powered up separately");
    pd_needs_ce_a: assert property (
        $fell(auxPowerDown) |-> $past(chipEnable, 3))
        else $error("power up without chip enable");
endmodule

bind scfg_regs scfg_regs_props chk (.*);

// *** scfg_regs_test.sv ***
// Self-checking bench for the serial configuration bank
module scfg_regs_test;
    import scfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk, arst_n, chipEnable, serClk, serData, serLatch;
    logic              mainLockDig, auxLockDig, mainLockAna, auxLockAna, refIn;
    logic              auxRefTick, auxFbTick, mainRefTick, mainFbTick;
    logic              testLockPinOut, testLockPinOe, mainPowerDown, auxPowerDown;
    logic              auxPrescaler16, mainPumpPositive, auxPumpPositive, refBufferOutEn;
    logic              mainRefClk, auxRefClk, fraction22;
    logic [1:0]        modulatorOrder, ditherLevel;
    logic [9:0]        extNumeratorHi, extDenominatorHi;
    logic [WORD_W-1:0] fastlockWord, testResetWord;
    int                errors = 0;
    int                n_checks = 0;
    logic [7:0]        mainRises = 8'h00;
    logic [7:0]        auxRises = 8'h00;
    logic              mainRefPrev = 1'b0;
    logic              auxRefPrev = 1'b0;
    // Pin {oe, data} for codes 0-11 with digital/analog locks main=1, aux=0
    localparam logic [1:0] PIN_EXP [12] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h3, 2'h2,
                                            2'h2, 2'h0, 2'h2, 2'h2, 2'h3, 2'h2};

    scfg_regs dut (.*);
    scfg_host host (.*);

    // Free-running 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Rising edges of both reference outputs, sampled mid-cycle
    always @(negedge clk) begin
        mainRefPrev <= mainRefClk;
        auxRefPrev  <= auxRefClk;
        if (mainRefClk && !mainRefPrev) begin
            mainRises <= mainRises + 8'h01;
        end
        if (auxRefClk && !auxRefPrev) begin
            auxRises <= auxRises + 8'h01;
        end
    end

    // Four reference periods of sixteen clocks each, ending low
    task automatic ref_cycles();
        repeat (8) begin
            refIn = ~refIn;
            repeat (8) @(negedge clk);
        end
    endtask

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One word, then wait until the pin mux has caught up
    task automatic wr(input logic [23:0] w);
        host.send(w);
        repeat (3) @(negedge clk);
    endtask

    // Dither, order, buffer, aux and main polarity, prescaler
    task automatic chk_loop(input logic [7:0] exp);
        check("loop fields", {ditherLevel, modulatorOrder, refBufferOutEn,
              auxPumpPositive, mainPumpPositive, auxPrescaler16}, exp);
    endtask

    task automatic chk_ext(input logic [20:0] exp);
        check("ext fraction", {fraction22, extNumeratorHi, extDenominatorHi}, exp);
    endtask

    // Hang guard, well beyond the roughly 6000 cycles of traffic
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        test_done();
    end

    // Main sequence; dividers and reference start quiet
    initial begin
        arst_n = 1'b0;
        chipEnable = 1'b0;
        {mainLockDig, auxLockDig, mainLockAna, auxLockAna, refIn} = 5'h00;
        {auxRefTick, auxFbTick, mainRefTick, mainFbTick} = 4'h0;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk_loop(8'hb7);
        check("pin oe", testLockPinOe, 1'b0);
        check("opt words", {fastlockWord, testResetWord}, {FAST_DEFAULT, TEST_DEFAULT});
        chk_ext(21'h0);
        // Base words first; an R0 write with auto power-up off keeps the loops down
        wr(24'h000000);
        wr(24'h000005);
        check("power down", {mainPowerDown, auxPowerDown}, 2'h3);
        // Loop word and fastlock word stored while still in default mode
        wr(24'ha11819);
        wr(24'habcded);
        chk_loop(8'hb7);
        check("fastlock", fastlockWord, FAST_DEFAULT);
        wr(24'h100007);
        chk_loop(8'h48);
        check("fastlock", fastlockWord, FAST_DEFAULT);
        // Auto power-up refused with chip enable low, taken once high
        wr(24'h000000);
        check("power down", {mainPowerDown, auxPowerDown}, 2'h3);
        chipEnable = 1'b1;
        wr(24'h000000);
        check("power down", {mainPowerDown, auxPowerDown}, 2'h0);
        // Chip enable low overrides, and releasing it restores power
        chipEnable = 1'b0;
        repeat (5) @(negedge clk);
        check("power down", {mainPowerDown, auxPowerDown}, 2'h3);
        chipEnable = 1'b1;
        repeat (5) @(negedge clk);
        check("power down", {mainPowerDown, auxPowerDown}, 2'h0);
        // Doubler on: one main reference edge per input edge
        ref_cycles();
        check("ref rises", {mainRises, auxRises}, {8'h08, 8'h04});
        {mainLockDig, mainLockAna} = 2'h3;
        for (int c = 0; c < 12; c++) begin
            wr(24'ha11809 | 24'(c << 4));
            check("test pin", {testLockPinOe, testLockPinOe & testLockPinOut}, PIN_EXP[c]);
        end
        // Codes 12-15: one divider pulse flips only its own halved output
        for (int k = 0; k < 4; k++) begin
            wr(24'ha118c9 | 24'(k << 4));
            check("halved tick", {testLockPinOe, testLockPinOut}, 2'h2);
            {mainFbTick, mainRefTick, auxFbTick, auxRefTick} = 4'(1 << k);
            @(negedge clk);
            {mainFbTick, mainRefTick, auxFbTick, auxRefTick} = 4'h0;
            repeat (2) @(negedge clk);
            check("halved tick", {testLockPinOe, testLockPinOut}, 2'h3);
        end
        // Optional words taken one at a time
        wr(24'h556aab);
        wr(24'h12345f);
        wr(24'h400007);
        check("fastlock", fastlockWord, 24'habcded);
        check("test word", testResetWord, TEST_DEFAULT);
        chk_ext(21'h0);
        chk_loop(8'hb7);
        // Doubler off in default mode: main reference follows the input
        ref_cycles();
        check("ref rises", {mainRises, auxRises}, {8'h0c, 8'h08});
        wr(24'hf00007);
        chk_ext({1'b1, 10'h2aa, 10'h155});
        check("test word", testResetWord, 24'h12345f);
        wr(24'h000007);
        check("opt words", {fastlockWord, testResetWord}, {FAST_DEFAULT, TEST_DEFAULT});
        chk_ext(21'h0);
        test_done();
    end
endmodule
